// ===== hw/fsi_pkg.sv
// Purpose: shared constants for the fault and status indicator block
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes: offsets are byte addresses of aligned 32-bit words
package fsi_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  // lamp test step length in milliseconds, and blink half period
  localparam int unsigned LAMP_STEP_MS = 500;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned LAMP_STEP_CYC = (CLK_HZ / 1000) * LAMP_STEP_MS;
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int CNT_W = 32;
  localparam int AW = 8;
  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_SETTINGS = 8'h08;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h10;
  // ctrl fields
  localparam int CTRL_REMOTE = 0;
  localparam int CTRL_RST_LATCHED = 1;
  localparam int CTRL_NV_CHECK = 2;
  // settings fields
  localparam int SET_CONTRAST_LSB = 0;
  localparam int SET_CONTRAST_W = 7;
  localparam int SET_TERM = 8;
  localparam int SET_LINK1 = 9;
  localparam int SET_LINK2 = 10;
  // defaults loaded after corruption found at power-up
  localparam logic [6:0] DEF_CONTRAST = 7'h4B; // 75 percent
  localparam logic DEF_TERM = 1'b1;
  localparam logic DEF_LINK = 1'b1;
  // interrupt status bits
  localparam int IRQ_NOCOMM = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_NVFAULT = 2;
  localparam int IRQ_LAMPDONE = 3;
  localparam int IRQ_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LAMP_MAIN, LAMP_UNIT, LAMP_DONE} fsi_lamp_t;
endpackage

// ===== hw/fsi_indicator.sv
// Purpose: lamp test, fault and link LED indication, persistent store fault handling
// Assumes: status inputs are synchronous to sys_clk_i except the noted pins
// Notes: all outputs registered; ce_i low freezes every flip-flop
module fsi_indicator
  import fsi_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic active_fault_i,
  input wire logic latched_fault_i,
  input wire logic link_ok_i,
  input wire logic unit_one_offline_i,
  input wire logic unit_two_offline_i,
  input wire logic unit_one_present_i,
  input wire logic unit_two_present_i,
  input wire logic amplifier_on_i,
  input wire logic nv_corrupt_i,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic amplifier_on_led_o,
  output logic fault_led_o,
  output logic unit_one_led_o,
  output logic unit_two_led_o,
  output logic online_one_led_o,
  output logic online_two_led_o,
  output logic reset_latched_o,
  output logic nocomm_msg_o,
  output logic persistent_store_fault_o,
  output logic irq_o
);

  // pin inputs pass two flops before any logic reads them
  logic [10:0] sync1_ff;
  logic [10:0] sync2_ff;
  logic s_act;
  logic s_lat;
  logic s_link;
  logic s_off1;
  logic s_off2;
  logic s_pres1;
  logic s_pres2;
  logic s_amp;
  logic s_nv;

  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else if (ce_i)
    begin
      sync1_ff <= {nv_corrupt_i, amplifier_on_i, unit_two_present_i, unit_one_present_i,
                   unit_two_offline_i, unit_one_offline_i, link_ok_i, latched_fault_i,
                   active_fault_i, 2'h0};
      sync2_ff <= sync1_ff;
    end

  assign s_act = sync2_ff[2];
  assign s_lat = sync2_ff[3];
  assign s_link = sync2_ff[4];
  assign s_off1 = sync2_ff[5];
  assign s_off2 = sync2_ff[6];
  assign s_pres1 = sync2_ff[7];
  assign s_pres2 = sync2_ff[8];
  assign s_amp = sync2_ff[9];
  assign s_nv = sync2_ff[10];

  // register state
  logic remote_ff;
  logic [6:0] contrast_ff;
  logic term_ff;
  logic link1_ff;
  logic link2_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic wr_go;
  logic [31:0] wr_data;
  logic [AW-1:0] wr_addr;

  // write channel: address and data held until both seen, then one response
  logic aw_have_ff;
  logic w_have_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end

  // decode used by both channels
  function automatic logic addr_ok(input logic [AW-1:0] a);
    addr_ok = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_SETTINGS) ||
              (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction

  assign wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;
  assign wr_addr = awaddr_ff;
  assign wr_data = wdata_ff;

  // ctrl register and the one-cycle reset-latched command
  logic nv_check_req;
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      remote_ff <= 1'b0;
      reset_latched_o <= 1'b0;
    end
    else if (ce_i)
    begin
      reset_latched_o <= 1'b0;
      if (wr_go && wr_addr == OFS_CTRL && wstrb_ff[0])
      begin
        remote_ff <= wr_data[CTRL_REMOTE];
        reset_latched_o <= wr_data[CTRL_RST_LATCHED];
      end
    end
  assign nv_check_req = wr_go && wr_addr == OFS_CTRL && wstrb_ff[0] && wr_data[CTRL_NV_CHECK];

  // persistent settings; the hand-held variant keeps contrast only
  logic powerup_chk_ff;
  // the synchroniser must fill before the power-up check may trust s_nv
  logic [1:0] warm_ff;
  logic pup_chk;
  assign pup_chk = powerup_chk_ff && warm_ff[1];
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
      warm_ff <= '0;
    else if (ce_i)
      warm_ff <= {warm_ff[0], 1'b1};

  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      contrast_ff <= DEF_CONTRAST;
      term_ff <= DEF_TERM;
      link1_ff <= DEF_LINK;
      link2_ff <= DEF_LINK;
      powerup_chk_ff <= 1'b1;
      persistent_store_fault_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (warm_ff[1])
        powerup_chk_ff <= 1'b0;
      if (wr_go && wr_addr == OFS_SETTINGS && wstrb_ff[0])
        contrast_ff <= wr_data[SET_CONTRAST_LSB +: SET_CONTRAST_W];
      if (wr_go && wr_addr == OFS_SETTINGS && wstrb_ff[1] && remote_ff)
      begin
        term_ff <= wr_data[SET_TERM];
        link1_ff <= wr_data[SET_LINK1];
        link2_ff <= wr_data[SET_LINK2];
      end
      // corruption seen at power-up or on request raises the flag; at power-up the defaults are loaded as well
      if ((pup_chk || nv_check_req) && s_nv)
        persistent_store_fault_o <= 1'b1;
      if (pup_chk && s_nv)
      begin
        contrast_ff <= DEF_CONTRAST;
        term_ff <= DEF_TERM;
        link1_ff <= DEF_LINK;
        link2_ff <= DEF_LINK;
      end
      if (wr_go && wr_addr == OFS_IRQ_STAT && wr_data[IRQ_NVFAULT])
        persistent_store_fault_o <= 1'b0;
    end

  // shared blink timebase; all three pairs toggle off the same phase bit
  logic [CNT_W-1:0] blink_cnt_ff;
  logic phase_ff;
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      blink_cnt_ff <= '0;
      phase_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (blink_cnt_ff == CNT_W'(BLINK_HALF_CYC - 1))
      begin
        blink_cnt_ff <= '0;
        phase_ff <= ~phase_ff;
      end
      else
        blink_cnt_ff <= blink_cnt_ff + 1'b1;
    end

  // lamp test sequencer
  fsi_lamp_t lamp_ff;
  logic [CNT_W-1:0] lamp_cnt_ff;
  logic lamp_end;
  assign lamp_end = lamp_cnt_ff == CNT_W'(LAMP_STEP_CYC - 1);
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      lamp_ff <= LAMP_MAIN;
      lamp_cnt_ff <= '0;
    end
    else if (ce_i)
    begin
      lamp_cnt_ff <= lamp_end ? '0 : lamp_cnt_ff + 1'b1;
      case (lamp_ff)
        LAMP_MAIN:
          if (lamp_end)
            lamp_ff <= remote_ff ? LAMP_UNIT : LAMP_DONE;
        LAMP_UNIT:
          if (lamp_end)
            lamp_ff <= LAMP_DONE;
        LAMP_DONE:
          lamp_cnt_ff <= '0;
        default:
          lamp_ff <= LAMP_DONE;
      endcase
    end

  // led drive; lamp test overrides, then no-link flashing, then status
  logic any_fault;
  assign any_fault = s_act || s_lat;
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      amplifier_on_led_o <= 1'b0;
      fault_led_o <= 1'b0;
      unit_one_led_o <= 1'b0;
      unit_two_led_o <= 1'b0;
      online_one_led_o <= 1'b0;
      online_two_led_o <= 1'b0;
      nocomm_msg_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // message is not held back by the lamp test, only the LEDs are
      nocomm_msg_o <= !s_link;
      if (lamp_ff == LAMP_MAIN)
      begin
        amplifier_on_led_o <= 1'b1;
        fault_led_o <= 1'b1;
        unit_one_led_o <= 1'b0;
        unit_two_led_o <= 1'b0;
        online_one_led_o <= 1'b0;
        online_two_led_o <= 1'b0;
      end
      else if (lamp_ff == LAMP_UNIT)
      begin
        amplifier_on_led_o <= 1'b0;
        fault_led_o <= 1'b0;
        unit_one_led_o <= 1'b1;
        unit_two_led_o <= 1'b1;
        online_one_led_o <= 1'b0;
        online_two_led_o <= 1'b0;
      end
      else
      begin
        // in phase pair for lost link
        amplifier_on_led_o <= s_link ? s_amp : phase_ff;
        fault_led_o <= s_link ? any_fault : phase_ff;
        if (remote_ff && !s_pres1 && !s_pres2)
        begin
          unit_one_led_o <= phase_ff;
          unit_two_led_o <= ~phase_ff;
        end
        else
        begin
          unit_one_led_o <= remote_ff && s_pres1 && link1_ff;
          unit_two_led_o <= remote_ff && s_pres2 && link2_ff;
        end
        if (remote_ff && s_off1 && s_off2)
        begin
          online_one_led_o <= phase_ff;
          online_two_led_o <= ~phase_ff;
        end
        else
        begin
          online_one_led_o <= !s_off1;
          online_two_led_o <= remote_ff && !s_off2;
        end
      end
    end

  // sticky events; a set in the same cycle beats a write-one clear
  logic [IRQ_W-1:0] ev;
  logic link_d_ff;
  logic fault_d_ff;
  logic [IRQ_W-1:0] clr;
  assign ev[IRQ_NOCOMM] = link_d_ff && !s_link;
  assign ev[IRQ_FAULT] = !fault_d_ff && any_fault;
  assign ev[IRQ_NVFAULT] = (pup_chk || nv_check_req) && s_nv;
  assign ev[IRQ_LAMPDONE] = lamp_ff != LAMP_DONE && lamp_end &&
                            (lamp_ff == LAMP_UNIT || !remote_ff);
  assign clr = (wr_go && wr_addr == OFS_IRQ_STAT) ? wr_data[IRQ_W-1:0] : '0;
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      link_d_ff <= 1'b0;
      fault_d_ff <= 1'b0;
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      link_d_ff <= s_link;
      fault_d_ff <= any_fault;
      irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
      if (wr_go && wr_addr == OFS_IRQ_MASK)
        irq_mask_ff <= wr_data[IRQ_W-1:0];
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end

  // read channel: one read at a time, data in the cycle after the address
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    case (s_axi_araddr)
      OFS_CTRL: rd_mux[CTRL_REMOTE] = remote_ff;
      OFS_STATUS: rd_mux[7:0] = {persistent_store_fault_o, s_pres2, s_pres1, s_off2,
                                 s_off1, s_link, s_lat, s_act};
      OFS_SETTINGS:
      begin
        rd_mux[SET_CONTRAST_LSB +: SET_CONTRAST_W] = contrast_ff;
        rd_mux[SET_TERM] = term_ff;
        rd_mux[SET_LINK1] = link1_ff;
        rd_mux[SET_LINK2] = link2_ff;
      end
      OFS_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_ff;
      OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_ff;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end

endmodule

// ===== test/fsi_unit_model.sv
// Purpose: behavioural up-converter unit on the far side of the indicator
// Assumes: bench sets the fault and link levels, unit keeps its own latch
// Notes: latched fault survives until the clear pulse arrives
module fsi_unit_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  input wire logic act_i,
  input wire logic lat_set_i,
  input wire logic link_i,
  output logic active_fault_o,
  output logic latched_fault_o,
  output logic link_ok_o
);
  // live levels pass straight out
  assign active_fault_o = act_i;
  assign link_ok_o = link_i;
  // latch holds until the controller asks to clear it
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      latched_fault_o <= 1'b0;
    else if (clr_i)
      latched_fault_o <= 1'b0;
    else if (lat_set_i)
      latched_fault_o <= 1'b1;
endmodule

// ===== test/fsi_indicator_chk.sv
// Purpose: port-level checks of the fault and status indicator
// Assumes: one clock domain, inputs pass a two-flop synchroniser
// Notes: window figures leave slack for the synchroniser delay
module fsi_chk (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic active_fault_i,
  input wire logic latched_fault_i,
  input wire logic link_ok_i,
  input wire logic unit_one_offline_i,
  input wire logic unit_two_offline_i,
  input wire logic nv_corrupt_i,
  input wire logic amplifier_on_led_o,
  input wire logic fault_led_o,
  input wire logic online_one_led_o,
  input wire logic online_two_led_o,
  input wire logic reset_latched_o,
  input wire logic nocomm_msg_o,
  input wire logic persistent_store_fault_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [9:0] up_cnt_ff;
  logic [5:0] flt_ff;
  // cycles since release, saturating well inside the first lamp step
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
      up_cnt_ff <= 10'h000;
    else if (up_cnt_ff != 10'h3E8)
      up_cnt_ff <= up_cnt_ff + 10'h001;
  // fault history, so a steady fault can be told from a glitch
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
      flt_ff <= 6'h00;
    else
      flt_ff <= {flt_ff[4:0], active_fault_i | latched_fault_i};
  a_lamp: assert property (p_lamp) else $error("lamp test LEDs dark");
  property p_lamp;
    up_cnt_ff >= 10'h003 && up_cnt_ff < 10'h3E8 |-> amplifier_on_led_o && fault_led_o;
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("fault LED dark on fault");
  property p_fault_keep;
    &flt_ff |-> fault_led_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("latch clear longer than one cycle");
  property p_pulse;
    reset_latched_o |=> !reset_latched_o;
  endproperty
  a_nocomm_on: assert property (p_nocomm_on) else $error("no-link message missing");
  property p_nocomm_on;
    (!link_ok_i) [*5] |=> nocomm_msg_o;
  endproperty
  a_nocomm_off: assert property (p_nocomm_off) else $error("no-link message with link");
  property p_nocomm_off;
    link_ok_i [*5] |=> !nocomm_msg_o;
  endproperty
  a_blink: assert property (p_blink) else $error("link flash out of phase");
  property p_blink;
    (!link_ok_i) [*5] |=> amplifier_on_led_o == fault_led_o;
  endproperty
  a_online: assert property (p_online) else $error("online LEDs lit together");
  property p_online;
    (unit_one_offline_i && unit_two_offline_i) [*5] |=> !(online_one_led_o && online_two_led_o);
  endproperty
  a_store: assert property (p_store) else $error("store fault without corruption");
  property p_store;
    $rose(persistent_store_fault_o) |-> $past(nv_corrupt_i, 3);
  endproperty
endmodule

bind fsi_indicator fsi_chk i_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .active_fault_i(active_fault_i), .latched_fault_i(latched_fault_i), .link_ok_i(link_ok_i),
  .unit_one_offline_i(unit_one_offline_i), .unit_two_offline_i(unit_two_offline_i),
  .nv_corrupt_i(nv_corrupt_i), .amplifier_on_led_o(amplifier_on_led_o),
  .fault_led_o(fault_led_o), .online_one_led_o(online_one_led_o),
  .online_two_led_o(online_two_led_o), .reset_latched_o(reset_latched_o),
  .nocomm_msg_o(nocomm_msg_o), .persistent_store_fault_o(persistent_store_fault_o));

// ===== test/fault_status_indicator_bench.sv
// Purpose: register-level bench for the fault and status indicator
// Assumes: lamp step far longer than the run, so LED timing stays in step one
// Notes: ready signals of responses held high throughout
module fault_status_indicator_bench import fsi_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, amplifier_on_i = 1'b1;
  logic act_q = 1'b0, lat_q = 1'b0, link_q = 1'b1, nv_corrupt_i = 1'b0;
  logic unit_one_offline_i = 1'b0, unit_two_offline_i = 1'b0;
  logic unit_one_present_i = 1'b0, unit_two_present_i = 1'b0;
  logic [AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic amplifier_on_led_o, fault_led_o, unit_one_led_o, unit_two_led_o;
  logic online_one_led_o, online_two_led_o, reset_latched_o, nocomm_msg_o;
  logic persistent_store_fault_o, irq_o, active_fault_i, latched_fault_i, link_ok_i;
  int errors = 0, total_checks = 0;
  // 100 MHz
  always #5 sys_clk_i = ~sys_clk_i;
  fsi_indicator i_dut (.*);
  fsi_unit_model i_unit (.clk_i(sys_clk_i), .rstn_i(resetn_i), .clr_i(reset_latched_o),
    .act_i(act_q), .lat_set_i(lat_q), .link_i(link_q), .active_fault_o(active_fault_i),
    .latched_fault_o(latched_fault_i), .link_ok_o(link_ok_i));
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  // write: offer address and data together, drop each once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk_i);
      if (s_axi_bvalid)
        break;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    r = s_axi_bresp;
    if (n == 50)
    begin
      errors++;
      close_out();
    end
  endtask
  // read: hold the address until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk_i);
      if (s_axi_rvalid)
        break;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 50)
    begin
      errors++;
      close_out();
    end
  endtask
  // main sequence, all inside the first lamp step
  initial
  begin
    tick(4);
    resetn_i <= 1'b1;
    tick(3);
    check({28'h0, amplifier_on_led_o, fault_led_o, unit_one_led_o, unit_two_led_o}, 32'hC);
    rd(OFS_CTRL);
    check(d, 32'h0);
    rd(OFS_SETTINGS);
    check(d, 32'h74B);
    rd(OFS_IRQ_MASK);
    check(d, 32'h0);
    rd(8'h14);
    check({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(OFS_IRQ_STAT, 32'hF);
    // hand-held keeps contrast only; remote also keeps termination and links
    wr(OFS_SETTINGS, 32'h020);
    rd(OFS_SETTINGS);
    check(d, 32'h720);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_SETTINGS, 32'h120);
    rd(OFS_SETTINGS);
    check(d, 32'h120);
    wr(OFS_CTRL, 32'h0);
    // active and latched fault, both units offline
    act_q <= 1'b1;
    lat_q <= 1'b1;
    {unit_one_offline_i, unit_two_offline_i} <= 2'h3;
    {unit_one_present_i, unit_two_present_i} <= 2'h3;
    tick(1);
    lat_q <= 1'b0;
    tick(8);
    rd(OFS_STATUS);
    check(d, 32'h7F);
    rd(OFS_IRQ_STAT);
    check(d, 32'h2);
    // clear command drops the unit's latch
    act_q <= 1'b0;
    wr(OFS_CTRL, 32'h2);
    tick(6);
    rd(OFS_STATUS);
    check(d, 32'h7C);
    // link loss: message, masked then unmasked interrupt
    wr(OFS_IRQ_STAT, 32'hF);
    link_q <= 1'b0;
    {unit_one_offline_i, unit_two_offline_i} <= 2'h0;
    tick(8);
    check({31'h0, nocomm_msg_o}, 32'h1);
    check({31'h0, irq_o}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    tick(3);
    check({31'h0, irq_o}, 32'h1);
    rd(OFS_IRQ_STAT);
    check(d, 32'h1);
    link_q <= 1'b1;
    tick(8);
    check({31'h0, nocomm_msg_o}, 32'h0);
    wr(OFS_IRQ_STAT, 32'h1);
    tick(3);
    check({31'h0, irq_o}, 32'h0);
    // store corruption found by a later check: flag only
    nv_corrupt_i <= 1'b1;
    tick(4);
    wr(OFS_CTRL, 32'h4);
    tick(4);
    check({31'h0, persistent_store_fault_o}, 32'h1);
    rd(OFS_STATUS);
    check(d, 32'hE4);
    rd(OFS_IRQ_STAT);
    check(d, 32'h4);
    check({31'h0, irq_o}, 32'h0);
    wr(OFS_IRQ_STAT, 32'h4);
    tick(3);
    check({31'h0, persistent_store_fault_o}, 32'h0);
    // second power-up with the store corrupt: flag raised, defaults held
    resetn_i <= 1'b0;
    tick(2);
    resetn_i <= 1'b1;
    tick(6);
    check({31'h0, persistent_store_fault_o}, 32'h1);
    rd(OFS_SETTINGS);
    check(d, 32'h74B);
    rd(OFS_IRQ_STAT);
    check(d, 32'h4);
    close_out();
  end
endmodule
